// File: ufc_ep0_irq.sv
// Endpoint0 control, interrupt masks and pending flags behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite interface to the registers.
`default_nettype none
// Operation
// [R01] IN mask: endpoints 3..0 enables at bits 3..0, reset all enabled.
// [R02] OUT mask: endpoints 3..1 at bits 3..1, reset enabled; bit 0 reads zero.
// [R03] Common mask: frame start, bus reset, resume, suspend at 3..0; reset 0x06.
// [R04] Interrupt line asserts only for pending flags whose enable is set.
// [R05] Engine handles protocol and interrupts on successful transfers.
// [R06] Receive interrupt only after whole packet; handshake given by hardware.
// [R07] Transmit interrupt only after packet sent and host handshake received.
// [R08] Corrupted received packets raise no interrupt.
// [R09] Firmware selects index zero before touching endpoint0 status.
// [R10] Received OUT or SETUP sets output-ready and endpoint0 interrupt.
// [R11] Sent IN packet clears input-ready and raises endpoint0 interrupt.
// [R12] Finished IN control transaction interrupts during status stage.
// [R13] Protocol violation sets stall-sent and raises endpoint0 interrupt.
// [R14] Transfer ended before data-end sets setup-end and interrupts.
// [R15] Count register holds received bytes in endpoint0 FIFO.
// [R16] Hardware stalls protocol errors; firmware may force a stall.
// [R17] Every endpoint0 stall sets stall-sent and raises an interrupt.
// [R18] OUT in OUT data phase after data-end is stalled.
// [R19] IN in IN data phase after data-end is stalled.
// [R20] Oversized endpoint0 packets are stalled.
// [R21] Status-stage DATA1 packet with payload is stalled.
// [R22] Send-stall bit forces a stall on endpoint0.
// [R23] Reading common flags clears all four common pending flags.
// [R24] IN token with input-ready clear is answered with NAK.
module ufc_ep0_irq
	import ufc_pkg::*;
#(
	parameter logic [10:0] MAX_PKT = 11'h040
) (
	// AHB-Lite clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Token from serial engine
	input  wire logic        tok_valid,
	input  wire ufc_pid_t    tok_kind,
	input  wire logic [1:0]  tok_ep,
	// Received data packet
	input  wire logic        rx_valid,
	input  wire logic [1:0]  rx_ep,
	input  wire logic        rx_setup,
	input  wire logic        rx_data1,
	input  wire logic        rx_err,
	input  wire logic [10:0] rx_len,
	// Host handshake after sent packet
	input  wire logic        tx_acked,
	input  wire logic [1:0]  tx_ep,
	// Other endpoint completions
	input  wire logic [2:0]  ep_in_done,
	input  wire logic [2:0]  ep_out_done,
	// Common bus events
	input  wire logic        sof_evt,
	input  wire logic        reset_evt,
	input  wire logic        resume_evt,
	input  wire logic        suspend_evt,
	// Handshake and data requests
	output logic             hs_valid,
	output ufc_hs_t          hs_code,
	output logic             tx_send,
	// Processor interrupt
	output logic             irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic        ap_valid;
	logic        ap_write;
	logic [7:0]  ap_idx;
	logic        rd_wait;
	logic        wr_now;
	logic        rd_now;
	logic [7:0]  wr_data;
	logic [7:0]  rd_val;
	logic        csr_ok;
	logic [7:0]  in_mask;
	logic [7:0]  out_mask;
	logic [7:0]  cm_mask;
	logic [7:0]  index;
	logic [3:0]  in_flags;
	logic [3:0]  out_flags;
	logic [3:0]  cm_flags;
	logic        output_packet_ready;
	logic        input_packet_ready;
	logic        stall_sent_flag;
	logic        dend;
	logic        setup_end_flag;
	logic        send_stall_bit;
	logic [10:0] e0_count;
	ufc_mode_t   mode;
	ufc_mode_t   next_mode;
	logic        ep0_tok;
	logic        ep0_rx;
	logic        ep0_ack;
	logic        hs_fire;
	ufc_hs_t     hs_sel;
	logic        send_fire;
	logic        set_output_packet_ready;
	logic        set_setup_end_flag;
	logic        clr_dend;
	logic        ep0_evt;
	logic        stall_fire;
	logic        csr_wr;

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	assign hresp = 1'b0;
	assign hreadyout = !rd_wait;
	assign wr_now = ap_valid && ap_write;
	assign rd_now = ap_valid && !ap_write && rd_wait;
	assign wr_data = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_idx   <= 8'h00;
		end else if (hready) begin
			ap_valid <= hsel && (htrans == UFC_HTRANS_NS);
			ap_write <= hwrite;
			ap_idx   <= haddr[9:2];
		end else if (rd_now) begin
			ap_valid <= 1'b0;
		end
	end

	// One wait state on reads, so read data and clear-on-read line up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_wait <= 1'b0;
		end else begin
			rd_wait <= hready && hsel && (htrans == UFC_HTRANS_NS) && !hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_now) begin
			hrdata <= {24'h00_0000, rd_val};
		end
	end

	assign csr_ok = (index == UFC_EP0_INDEX); // see [R09]

	always_comb begin
		rd_val = 8'h00;
		unique case (ap_idx)
			UFC_IDX_IN_FLAGS:  rd_val = {4'h0, in_flags};
			UFC_IDX_OUT_FLAGS: rd_val = {4'h0, out_flags};
			UFC_IDX_CM_FLAGS:  rd_val = {4'h0, cm_flags};
			UFC_IDX_IN_MASK:   rd_val = in_mask;
			UFC_IDX_OUT_MASK:  rd_val = out_mask;
			UFC_IDX_CM_MASK:   rd_val = cm_mask;
			UFC_IDX_INDEX:     rd_val = index;
			UFC_IDX_E0_CSR:    rd_val = csr_ok ? {2'h0, send_stall_bit, setup_end_flag, dend, stall_sent_flag, input_packet_ready, output_packet_ready} : 8'h00;
			UFC_IDX_E0_COUNT:  rd_val = csr_ok ? e0_count[7:0] : 8'h00; // see [R15]
			default:           rd_val = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Mask and index registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_mask  <= UFC_RST_IN_MASK; // see [R01]
			out_mask <= UFC_RST_OUT_MASK; // see [R02]
			cm_mask  <= UFC_RST_CM_MASK; // see [R03]
			index    <= UFC_EP0_INDEX;
		end else if (wr_now) begin
			if (ap_idx == UFC_IDX_IN_MASK) begin
				in_mask <= wr_data & UFC_WR_IN_MASK; // see [R01]
			end
			if (ap_idx == UFC_IDX_OUT_MASK) begin
				out_mask <= wr_data & UFC_WR_OUT_MASK; // see [R02]
			end
			if (ap_idx == UFC_IDX_CM_MASK) begin
				cm_mask <= wr_data & UFC_WR_CM_MASK; // see [R03]
			end
			if (ap_idx == UFC_IDX_INDEX) begin
				index <= wr_data;
			end
		end
	end

	// ------------------------------------------------------------
	// Endpoint0 decode and handshake choice
	// ------------------------------------------------------------
	assign ep0_tok = tok_valid && (tok_ep == 2'h0);
	assign ep0_rx  = rx_valid && !rx_err && (rx_ep == 2'h0); // see [R08]
	assign ep0_ack = tx_acked && (tx_ep == 2'h0);
	assign csr_wr  = wr_now && (ap_idx == UFC_IDX_E0_CSR) && csr_ok; // see [R09]
	assign stall_fire = hs_fire && (hs_sel == UFC_HS_STALL);

	always_comb begin
		hs_fire   = 1'b0;
		hs_sel    = UFC_HS_ACK;
		send_fire = 1'b0;
		set_output_packet_ready = 1'b0;
		set_setup_end_flag = 1'b0;
		clr_dend  = 1'b0;
		ep0_evt   = 1'b0;
		next_mode = mode;
		if (ep0_tok) begin
			if ((tok_kind != UFC_PID_OUT) && (mode == UFC_M_RX) && !dend) begin
				set_setup_end_flag = 1'b1; // see [R14]
			end
			if ((tok_kind != UFC_PID_IN) && (mode == UFC_M_TX) && !dend) begin
				set_setup_end_flag = 1'b1; // see [R14]
			end
			if (tok_kind == UFC_PID_IN) begin
				hs_fire = 1'b1;
				if (send_stall_bit) begin
					hs_sel = UFC_HS_STALL; // see [R22]
				end else if ((mode == UFC_M_STAT) || ((mode == UFC_M_TX) && dend && !input_packet_ready)) begin
					hs_sel = UFC_HS_STALL; // see [R19]
				end else if (!input_packet_ready) begin
					hs_sel = UFC_HS_NAK; // see [R24]
				end else begin
					hs_fire   = 1'b0;
					send_fire = 1'b1;
					next_mode = UFC_M_TX;
				end
			end else if (mode == UFC_M_TX) begin
				next_mode = UFC_M_IDLE;
			end
		end
		if (ep0_rx && rx_setup) begin
			if (rx_len == UFC_SETUP_LEN) begin
				hs_fire   = 1'b1;
				set_output_packet_ready = 1'b1; // see [R10]
				clr_dend  = 1'b1;
				next_mode = UFC_M_IDLE;
			end
		end else if (ep0_rx) begin
			hs_fire = 1'b1;
			if (send_stall_bit) begin
				hs_sel = UFC_HS_STALL; // see [R22]
			end else if (rx_len > MAX_PKT) begin
				hs_sel = UFC_HS_STALL; // see [R20]
			end else if ((mode == UFC_M_RX) && dend) begin
				hs_sel = UFC_HS_STALL; // see [R18]
			end else if ((mode == UFC_M_STAT) && rx_data1 && (rx_len != 11'h000)) begin
				hs_sel = UFC_HS_STALL; // see [R21]
			end else if (mode == UFC_M_STAT) begin
				ep0_evt   = 1'b1; // see [R12]
				clr_dend  = 1'b1;
				next_mode = UFC_M_IDLE;
			end else if (output_packet_ready) begin
				hs_sel = UFC_HS_NAK;
			end else begin
				set_output_packet_ready = 1'b1; // see [R06]
				next_mode = UFC_M_RX;
			end
		end
		if (ep0_ack) begin
			ep0_evt = 1'b1; // see [R11]
			if (dend) begin
				next_mode = UFC_M_STAT;
			end
		end
		if (hs_fire && (hs_sel == UFC_HS_STALL)) begin
			next_mode = UFC_M_IDLE; // see [R16]
		end
		if (set_output_packet_ready || set_setup_end_flag || (hs_fire && (hs_sel == UFC_HS_STALL))) begin
			ep0_evt = 1'b1; // see [R17]
		end
	end

	// ------------------------------------------------------------
	// Handshake outputs and mode
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hs_valid <= 1'b0;
			hs_code  <= UFC_HS_ACK;
			tx_send  <= 1'b0;
		end else begin
			hs_valid <= hs_fire; // see [R06]
			hs_code  <= hs_sel;
			tx_send  <= send_fire; // see [R05]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= UFC_M_IDLE;
		end else begin
			mode <= next_mode;
		end
	end

	// ------------------------------------------------------------
	// Endpoint0 control/status bits and byte count
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_packet_ready    <= 1'b0;
			e0_count <= 11'h000;
		end else if (set_output_packet_ready) begin
			output_packet_ready    <= 1'b1; // see [R10]
			e0_count <= rx_len; // see [R15]
		end else if (csr_wr && wr_data[UFC_CSR_SOPRDY]) begin
			output_packet_ready    <= 1'b0;
			e0_count <= 11'h000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			input_packet_ready <= 1'b0;
		end else if (ep0_ack) begin
			input_packet_ready <= 1'b0; // see [R11]
		end else if (csr_wr && wr_data[UFC_CSR_INPUT_PACKET_READY]) begin
			input_packet_ready <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stall_sent_flag <= 1'b0;
		end else if (stall_fire) begin
			stall_sent_flag <= 1'b1; // see [R13]
		end else if (csr_wr && !wr_data[UFC_CSR_STALL_SENT_FLAG]) begin
			stall_sent_flag <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			setup_end_flag <= 1'b0;
		end else if (set_setup_end_flag) begin
			setup_end_flag <= 1'b1; // see [R14]
		end else if (csr_wr && wr_data[UFC_CSR_SSUEND]) begin
			setup_end_flag <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dend <= 1'b0;
		end else if (csr_wr && wr_data[UFC_CSR_DEND]) begin
			dend <= 1'b1;
		end else if (clr_dend || stall_fire) begin
			dend <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			send_stall_bit <= 1'b0;
		end else if (csr_wr) begin
			send_stall_bit <= wr_data[UFC_CSR_SEND_STALL_BIT]; // see [R22]
		end
	end

	// ------------------------------------------------------------
	// Pending flags, set wins over clear-on-read
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_flags  <= 4'h0;
			out_flags <= 4'h0;
			cm_flags  <= 4'h0;
		end else begin
			in_flags <= ((rd_now && (ap_idx == UFC_IDX_IN_FLAGS)) ? 4'h0 : in_flags)
				| {ep_in_done, ep0_evt}; // see [R07]
			out_flags <= ((rd_now && (ap_idx == UFC_IDX_OUT_FLAGS)) ? 4'h0 : out_flags)
				| {ep_out_done, 1'b0}; // see [R06]
			cm_flags <= ((rd_now && (ap_idx == UFC_IDX_CM_FLAGS)) ? 4'h0 : cm_flags) // see [R23]
				| {sof_evt, reset_evt, resume_evt, suspend_evt};
		end
	end

	// ------------------------------------------------------------
	// Interrupt line
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(in_flags & in_mask[3:0])
				| |(out_flags & out_mask[3:0])
				| |(cm_flags & cm_mask[3:0]); // see [R04]
		end
	end

endmodule
`default_nettype wire

// File: ufc_ep0_irq_bench.sv
// Self-checking bench for the endpoint0 and interrupt block
`default_nettype none
module ufc_ep0_irq_bench;
	import ufc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, hreadyout, hresp, irq, hs_valid, tx_send;
	logic        tok_valid, rx_valid, rx_setup, rx_data1, rx_err, tx_acked;
	logic [1:0]  htrans, tok_ep, rx_ep, tx_ep;
	logic [2:0]  hsize, ep_in_done, ep_out_done;
	logic [3:0]  bus_evt;
	logic [10:0] rx_len;
	logic [31:0] haddr, hwdata, hrdata, rd;
	ufc_pid_t    tok_kind;
	ufc_hs_t     hs_code;
	int          err_count = 0;
	int          n_compared = 0;
	int          nh;
	always #2 hclk = ~hclk;
	ufc_ep0_irq #(.MAX_PKT(11'h040)) dut (.hready(hreadyout), .sof_evt(bus_evt[3]), .reset_evt(bus_evt[2]),
		.resume_evt(bus_evt[1]), .suspend_evt(bus_evt[0]), .*);
	ufc_host host (.*);
	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic chk(input logic [31:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wt();
		logic ok;
		for (int i = 0; i < 20; i++) begin
			@(negedge hclk);
			ok = (hreadyout === 1'b1);
			@(posedge hclk);
			if (ok)
				return;
		end
		chk(32'h0, 32'h1, "bus timeout");
		end_of_test();
	endtask
	task automatic bus(input logic w, input logic [7:0] a, d);
		{hsel, htrans, hwrite, haddr} <= {1'b1, UFC_HTRANS_NS, w, 22'h0, a, 2'h0};
		wt();
		{htrans, hwdata} <= {2'h0, 24'h0, d};
		wt();
		rd = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 8'h00);
		chk(rd, e, m);
	endtask
	task automatic tx(input ufc_pid_t p, input logic d1, input logic [10:0] n, input ufc_hs_t c);
		nh = host.n_hs;
		host.tok(p);
		if (p != UFC_PID_IN)
			host.pkt(p == UFC_PID_SETUP, d1, 1'b0, n);
		repeat (3) @(posedge hclk);
		chk(host.n_hs, nh + 1, "handshake count");
		chk(host.last_hs, c, "handshake code");
	endtask
	task automatic fresh();
		tx(UFC_PID_SETUP, 1'b0, UFC_SETUP_LEN, UFC_HS_ACK);
		bus(1'b1, UFC_IDX_E0_CSR, 8'hc0);
		bus(1'b0, UFC_IDX_IN_FLAGS, 8'h00);
	endtask
	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_regs();
		logic [7:0] ix[3];
		logic [7:0] rv[3];
		logic [7:0] wm[3];
		ix = '{UFC_IDX_IN_MASK, UFC_IDX_OUT_MASK, UFC_IDX_CM_MASK};
		rv = '{8'h0f, 8'h0e, 8'h06};
		wm = '{8'h0f, 8'h0e, 8'h0f};
		for (int i = 0; i < 3; i++) begin
			rdc(ix[i], {24'h0, rv[i]}, "mask reset");
			bus(1'b1, ix[i], 8'hff);
			rdc(ix[i], {24'h0, wm[i]}, "mask bits");
			bus(1'b1, ix[i], 8'h00);
		end
		bus(1'b1, 8'h30, 8'hff);
		rdc(8'h30, 32'h0, "unmapped");
	endtask
	task automatic t_out();
		bus(1'b1, UFC_IDX_INDEX, UFC_EP0_INDEX);
		tx(UFC_PID_SETUP, 1'b0, UFC_SETUP_LEN, UFC_HS_ACK);
		rdc(UFC_IDX_E0_COUNT, 32'h8, "setup count");
		bus(1'b1, UFC_IDX_E0_CSR, 8'h40);
		tx(UFC_PID_OUT, 1'b0, 11'h040, UFC_HS_ACK);
		rdc(UFC_IDX_E0_CSR, 32'h1, "output ready");
		rdc(UFC_IDX_E0_COUNT, 32'h40, "out count");
		chk(irq, 1'b0, "masked irq");
		bus(1'b1, UFC_IDX_IN_MASK, 8'h01);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b1, "enabled irq");
		bus(1'b1, UFC_IDX_INDEX, 8'h01);
		rdc(UFC_IDX_E0_CSR, 32'h0, "other index");
		bus(1'b1, UFC_IDX_INDEX, UFC_EP0_INDEX);
		rdc(UFC_IDX_IN_FLAGS, 32'h1, "ep0 flag");
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0, "flag read");
		bus(1'b1, UFC_IDX_E0_CSR, 8'h40);
	endtask
	task automatic t_err();
		nh = host.n_hs;
		host.tok(UFC_PID_OUT);
		host.pkt(1'b0, 1'b0, 1'b1, 11'h005);
		repeat (3) @(posedge hclk);
		chk(host.n_hs, nh, "corrupt answered");
		chk(irq, 1'b0, "corrupt irq");
		rdc(UFC_IDX_E0_CSR, 32'h0, "corrupt stored");
	endtask
	task automatic t_setup_end_flag();
		tx(UFC_PID_IN, 1'b0, 11'h000, UFC_HS_NAK);
		rdc(UFC_IDX_E0_CSR, 32'h10, "setup end");
		rdc(UFC_IDX_IN_FLAGS, 32'h1, "setup end flag");
	endtask
	task automatic t_in(input int k);
		int n0;
		fresh();
		bus(1'b1, UFC_IDX_E0_CSR, 8'h0a);
		n0 = host.n_tx;
		host.tok(UFC_PID_IN);
		repeat (2) @(posedge hclk);
		chk(host.n_tx, n0 + 1, "packet sent");
		chk(irq, 1'b0, "irq before ack");
		host.ack(3 * k);
		repeat (3) @(posedge hclk);
		bus(1'b0, UFC_IDX_E0_CSR, 8'h00);
		chk(rd[1], 1'b0, "input ready");
		rdc(UFC_IDX_IN_FLAGS, 32'h1, "sent flag");
		if (k == 0) begin
			tx(UFC_PID_OUT, 1'b1, 11'h000, UFC_HS_ACK);
			rdc(UFC_IDX_IN_FLAGS, 32'h1, "status flag");
		end else begin
			tx(k == 1 ? UFC_PID_OUT : UFC_PID_IN, 1'b1, 11'h003, UFC_HS_STALL);
			rdc(UFC_IDX_E0_CSR, 32'h4, "stall sent");
			rdc(UFC_IDX_IN_FLAGS, 32'h1, "stall flag");
		end
	endtask
	task automatic t_big();
		fresh();
		tx(UFC_PID_OUT, 1'b0, 11'h040, UFC_HS_ACK);
		bus(1'b1, UFC_IDX_E0_CSR, 8'h48);
		tx(UFC_PID_OUT, 1'b0, 11'h040, UFC_HS_STALL);
		fresh();
		tx(UFC_PID_OUT, 1'b0, 11'h041, UFC_HS_STALL);
		rdc(UFC_IDX_E0_CSR, 32'h4, "stall sent");
		bus(1'b1, UFC_IDX_E0_CSR, 8'h20);
		tx(UFC_PID_IN, 1'b0, 11'h000, UFC_HS_STALL);
		rdc(UFC_IDX_E0_CSR, 32'h24, "forced stall");
		bus(1'b1, UFC_IDX_E0_CSR, 8'h00);
		bus(1'b0, UFC_IDX_IN_FLAGS, 8'h00);
	endtask
	task automatic t_common();
		bus(1'b1, UFC_IDX_IN_MASK, 8'h00);
		host.pulse(3'h7, 3'h7, 4'hf);
		repeat (3) @(posedge hclk);
		chk(irq, 1'b0, "all masked");
		bus(1'b1, UFC_IDX_CM_MASK, 8'h01);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b1, "suspend enabled");
		rdc(UFC_IDX_CM_FLAGS, 32'hf, "common flags");
		rdc(UFC_IDX_CM_FLAGS, 32'h0, "common cleared");
		rdc(UFC_IDX_IN_FLAGS, 32'he, "in flags");
		rdc(UFC_IDX_OUT_FLAGS, 32'he, "out flags");
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0, "none pending");
	endtask
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_out();
		t_err();
		t_setup_end_flag();
		for (int k = 0; k < 3; k++)
			t_in(k);
		t_big();
		t_common();
		end_of_test();
	end
endmodule
`default_nettype wire

// File: ufc_ep0_irq_properties.sv
// Port checks for the endpoint0 and interrupt block
`default_nettype none
module ufc_ep0_irq_properties
	import ufc_pkg::*;
(
	// Clock, reset and bus
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic [31:0] hrdata,
	// Serial engine and events
	input  wire logic        tok_valid,
	input  wire ufc_pid_t    tok_kind,
	input  wire logic [1:0]  tok_ep,
	input  wire logic        rx_valid,
	input  wire logic [1:0]  rx_ep,
	input  wire logic        rx_setup,
	input  wire logic        rx_err,
	input  wire logic [10:0] rx_len,
	input  wire logic        tx_acked,
	input  wire logic [2:0]  ep_in_done,
	input  wire logic [2:0]  ep_out_done,
	input  wire logic        sof_evt,
	input  wire logic        reset_evt,
	input  wire logic        resume_evt,
	input  wire logic        suspend_evt,
	// Answers
	input  wire logic        hs_valid,
	input  wire ufc_hs_t     hs_code,
	input  wire logic        tx_send,
	input  wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------
	// Helpers
	// ------------------------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic       ev;
	logic [2:0] since_ev;
	assign ev = tok_valid | rx_valid | tx_acked | sof_evt | reset_evt | resume_evt | suspend_evt
		| (|ep_in_done) | (|ep_out_done) | (hsel & hready & hwrite & (htrans == UFC_HTRANS_NS));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			since_ev <= 3'h7;
		else if (ev)
			since_ev <= 3'h0;
		else if (since_ev != 3'h7)
			since_ev <= since_ev + 3'h1;
	end
	sequence take_s;
		hsel && hready && htrans == UFC_HTRANS_NS;
	endsequence
	sequence one_wait_s;
		!hreadyout ##1 hreadyout;
	endsequence
	// ------------------------------
	// Assertions
	// ------------------------------
	a_read_one_wait: assert property (take_s ##0 !hwrite |=> one_wait_s)
		else $error("read data phase not one wait");
	a_write_no_wait: assert property (take_s ##0 hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_corrupt_silent: assert property (rx_valid && rx_err && !tok_valid |=> !hs_valid)
		else $error("corrupt packet answered");
	a_hs_has_cause: assert property (hs_valid |-> $past(tok_valid || (rx_valid && !rx_err)))
		else $error("handshake without token or packet");
	a_send_needs_in: assert property (tx_send |-> $past(tok_valid && tok_kind == UFC_PID_IN && tok_ep == 2'h0))
		else $error("send without endpoint0 in token");
	a_irq_has_cause: assert property ($rose(irq) |-> since_ev <= 3'h5)
		else $error("interrupt without event");
	a_setup_acked: assert property (rx_valid && !rx_err && rx_setup && rx_ep == 2'h0
		&& rx_len == UFC_SETUP_LEN |=> hs_valid && hs_code == UFC_HS_ACK)
		else $error("setup packet not acked");
endmodule
bind ufc_ep0_irq ufc_ep0_irq_properties chk (.*);
`default_nettype wire

// File: ufc_host.sv
// Host model driving the serial engine side
`default_nettype none
module ufc_host
	import ufc_pkg::*;
(
	// Clock and device answers
	input  wire logic     hclk,
	input  wire logic     hs_valid,
	input  wire ufc_hs_t  hs_code,
	input  wire logic     tx_send,
	// Token, packet and handshake
	output logic          tok_valid,
	output ufc_pid_t      tok_kind,
	output logic [1:0]    tok_ep,
	output logic          rx_valid,
	output logic [1:0]    rx_ep,
	output logic          rx_setup,
	output logic          rx_data1,
	output logic          rx_err,
	output logic [10:0]   rx_len,
	output logic          tx_acked,
	output logic [1:0]    tx_ep,
	// Other endpoints and bus events
	output logic [2:0]    ep_in_done,
	output logic [2:0]    ep_out_done,
	output logic [3:0]    bus_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	ufc_hs_t last_hs;
	int      n_hs = 0;
	int      n_tx = 0;
	initial begin
		{tok_valid, rx_valid, tx_acked, rx_setup, rx_data1, rx_err, tx_ep} = '0;
		{tok_ep, rx_ep, rx_len} = '1;
		{ep_in_done, ep_out_done, bus_evt} = '0;
		tok_kind = UFC_PID_OUT;
	end
	always @(posedge hclk) begin
		if (hs_valid === 1'b1) begin
			last_hs <= hs_code;
			n_hs <= n_hs + 1;
		end
		if (tx_send === 1'b1)
			n_tx <= n_tx + 1;
	end
	task automatic tok(input ufc_pid_t k);
		@(posedge hclk);
		{tok_valid, tok_kind, tok_ep} <= {1'b1, k, 2'h0};
		@(posedge hclk);
		{tok_valid, tok_ep} <= {1'b0, 2'h3};
	endtask
	task automatic pkt(input logic s, d1, e, input logic [10:0] n);
		@(posedge hclk);
		{rx_valid, rx_ep, rx_setup, rx_data1, rx_err, rx_len} <= {1'b1, 2'h0, s, d1, e, n};
		@(posedge hclk);
		{rx_valid, rx_ep, rx_len} <= {1'b0, 2'h3, ~n};
	endtask
	task automatic ack(input int d);
		repeat (d + 1) @(posedge hclk);
		tx_acked <= 1'b1;
		@(posedge hclk);
		tx_acked <= 1'b0;
	endtask
	task automatic pulse(input logic [2:0] i, o, input logic [3:0] b);
		@(posedge hclk);
		{ep_in_done, ep_out_done, bus_evt} <= {i, o, b};
		@(posedge hclk);
		{ep_in_done, ep_out_done, bus_evt} <= '0;
	endtask
endmodule
`default_nettype wire

// File: ufc_pkg.sv
// Shared constants and types for the USB function endpoint0/interrupt block
`default_nettype none
package ufc_pkg;
	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] UFC_IDX_IN_FLAGS  = 8'h02;
	localparam logic [7:0] UFC_IDX_OUT_FLAGS = 8'h04;
	localparam logic [7:0] UFC_IDX_CM_FLAGS  = 8'h06;
	localparam logic [7:0] UFC_IDX_IN_MASK   = 8'h07;
	localparam logic [7:0] UFC_IDX_OUT_MASK  = 8'h09;
	localparam logic [7:0] UFC_IDX_CM_MASK   = 8'h0b;
	localparam logic [7:0] UFC_IDX_INDEX     = 8'h0e;
	localparam logic [7:0] UFC_IDX_E0_CSR    = 8'h11;
	localparam logic [7:0] UFC_IDX_E0_COUNT  = 8'h16;
	// ------------------------------------------------------------
	// Reset values and writable bits
	// ------------------------------------------------------------
	localparam logic [7:0] UFC_RST_IN_MASK   = 8'h0f;
	localparam logic [7:0] UFC_RST_OUT_MASK  = 8'h0e;
	localparam logic [7:0] UFC_RST_CM_MASK   = 8'h06;
	localparam logic [7:0] UFC_WR_IN_MASK    = 8'h0f;
	localparam logic [7:0] UFC_WR_OUT_MASK   = 8'h0e;
	localparam logic [7:0] UFC_WR_CM_MASK    = 8'h0f;
	localparam logic [7:0] UFC_EP0_INDEX     = 8'h00;
	// ------------------------------------------------------------
	// Endpoint0 control/status bit positions
	// ------------------------------------------------------------
	localparam int UFC_CSR_OUTPUT_PACKET_READY  = 0;
	localparam int UFC_CSR_INPUT_PACKET_READY = 1;
	localparam int UFC_CSR_STALL_SENT_FLAG  = 2;
	localparam int UFC_CSR_DEND   = 3;
	localparam int UFC_CSR_SETUP_END_FLAG  = 4;
	localparam int UFC_CSR_SEND_STALL_BIT  = 5;
	localparam int UFC_CSR_SOPRDY = 6;
	localparam int UFC_CSR_SSUEND = 7;
	// ------------------------------------------------------------
	// Protocol constants and types
	// ------------------------------------------------------------
	localparam logic [10:0] UFC_SETUP_LEN = 11'h008;
	localparam logic [1:0]  UFC_HTRANS_NS = 2'h2;
	typedef enum logic [1:0] {UFC_PID_OUT, UFC_PID_IN, UFC_PID_SETUP} ufc_pid_t;
	typedef enum logic [1:0] {UFC_HS_ACK, UFC_HS_NAK, UFC_HS_STALL} ufc_hs_t;
	typedef enum logic [1:0] {UFC_M_IDLE, UFC_M_TX, UFC_M_RX, UFC_M_STAT} ufc_mode_t;
endpackage
`default_nettype wire
